// >>> logic/pstat_consts.svh
/*
 * Bit positions, reset values and widths of the basic link status register.
 * Assumes inclusion by pstat_core and the bench tb of this block.
 */
`ifndef PSTAT_CONSTS_SVH
`define PSTAT_CONSTS_SVH

`define PSTAT_REG_ADDR      5'h01
`define PSTAT_DETAIL_ADDR   5'h11
`define PSTAT_PARTNER_ADDR  5'h05
`define PSTAT_BIT_T4        15
`define PSTAT_BIT_TX_FD     14
`define PSTAT_BIT_TX_HD     13
`define PSTAT_BIT_T_FD      12
`define PSTAT_BIT_T_HD      11
`define PSTAT_BIT_PRE_SUP   6
`define PSTAT_BIT_AN_DONE   5
`define PSTAT_BIT_RFAULT    4
`define PSTAT_BIT_AN_ABLE   3
`define PSTAT_BIT_LINK      2
`define PSTAT_BIT_JABBER    1
`define PSTAT_BIT_EXT_CAP   0
`define PSTAT_CAP_RESET     4'hF
`define PSTAT_PRE_RESET     1'h0
`define PSTAT_PARTNER_RF    13
`define PSTAT_DETAIL_JAB    2
`define PSTAT_DETAIL_RF     1
`define PSTAT_DETAIL_LINK   0

`endif

// >>> logic/pstat_pkg.sv
/*
 * Types shared by the status register block.
 * Assumes pstat_consts.svh is on the include path.
 */
`default_nettype none
package pstat_pkg;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} pstat_acc_t;

	typedef struct packed {
		logic an_enable;
		logic an_done;
		logic lcw_valid;
		logic lcw_rfault;
		logic link_ok;
		logic jab_enable;
		logic jab_event;
		logic override_en;
	} pstat_ev_t;

	typedef enum logic [1:0] {
		PSTAT_LATCH_HIGH,
		PSTAT_LATCH_LOW
	} pstat_kind_t;
endpackage
`default_nettype wire

// >>> logic/pstat_latch.sv
/*
 * One latching status bit: holds its event until read, then shows the live level.
 * Assumes the read strobe is one cycle long and on the same clock.
 */
`default_nettype none
module pstat_latch
	import pstat_pkg::*;
#(
	parameter pstat_kind_t KIND = PSTAT_LATCH_HIGH
) (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic live,
	input  wire logic rd_clr,
	output logic      q
);
	logic event_seen;
	logic next_q;

	// an event in the read cycle still wins over the clear
	assign event_seen = (KIND == PSTAT_LATCH_HIGH) ? live : ~live;
	assign next_q = (KIND == PSTAT_LATCH_HIGH)
		? (event_seen | (q & ~rd_clr) | (rd_clr & live))
		: ((q & ~rd_clr & ~event_seen) | (rd_clr & live));

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			q <= (KIND == PSTAT_LATCH_HIGH) ? 1'b0 : 1'b0;
		end else begin
			q <= next_q;
		end
	end
endmodule // pstat_latch
`default_nettype wire

// >>> logic/pstat_core.sv
/*
 * Basic link status register with shared latching bits and override-writable capability bits.
 * Assumes a management frame engine on ref_clk that issues one-cycle read and write strobes,
 * and event inputs from the negotiation, link and jabber logic on the same clock.
 */
// Contract
// - 100Base-T4 bit always reads zero; writes to it ignored.
// - 100TX full-duplex bit resets to one, writable only under override.
// - 100TX half-duplex bit resets to one, writable only under override.
// - 10T full-duplex bit resets to one, writable only under override.
// - 10T half-duplex bit resets to one, writable only under override.
// - Reserved bits ten down to seven read zero.
// - Override-writable bits take writes only while override enable is one.
// - Preamble suppression bit resets zero, override-writable, one enables headerless frames.
// - Negotiation complete held zero while disabled; set only when negotiation finishes.
// - Negotiation complete latches high; restart does not clear it.
// - Remote fault follows flag of each received code word.
// - Remote fault is one latching bit cleared by either register read.
// - Non-latching remote fault copy refreshed by every code word.
// - Negotiation ability bit always reads one.
// - Link status latches low, shared with detailed status register.
// - Link validity judged outside from receiver, link state, errors, negotiation.
// - Jabber bit forced zero while jabber disabled; set on detected jabber.
// - Jabber bit latches high, cleared by read of either register.
// - Extended capability bit always reads one.
`default_nettype none
`include "pstat_consts.svh"
module pstat_core
	import pstat_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire pstat_acc_t  acc,
	input  wire pstat_ev_t   ev,
	output logic [15:0]      rdata,
	output logic [15:0]      detail_bits,
	output logic             partner_rfault,
	output logic             preamble_skip_en
);
	logic [3:0]  cap;
	logic        pre_sup;
	logic        an_live;
	logic        rf_live;
	logic        rf_hold;
	logic        jab_live;
	logic        an_q;
	logic        rf_q;
	logic        link_q;
	logic        jab_q;
	logic        rd_status;
	logic        rd_detail;
	logic        rd_shared;
	logic        wr_status;
	logic        ow_write;
	logic [15:0] status_word;
	logic [15:0] next_rdata;
	logic [3:0]  next_cap;
	logic        next_pre_sup;
	logic        next_rf_hold;
	logic        next_partner_rfault;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
		hit = (a == b);
	endfunction

	assign rd_status = acc.rd & hit(acc.addr, `PSTAT_REG_ADDR);
	assign rd_detail = acc.rd & hit(acc.addr, `PSTAT_DETAIL_ADDR);
	assign rd_shared = rd_status | rd_detail;
	assign wr_status = acc.wr & hit(acc.addr, `PSTAT_REG_ADDR);
	assign ow_write  = wr_status & ev.override_en;

	assign next_cap = ow_write
		? acc.wdata[`PSTAT_BIT_TX_FD:`PSTAT_BIT_T_HD] : cap;
	assign next_pre_sup = ow_write ? acc.wdata[`PSTAT_BIT_PRE_SUP] : pre_sup;

	// negotiation done only counts while negotiation is enabled
	assign an_live  = ev.an_enable & ev.an_done;
	// remote fault level follows the flag of the newest code word
	assign next_rf_hold = ev.lcw_valid ? ev.lcw_rfault : rf_hold;
	assign next_partner_rfault = ev.lcw_valid ? ev.lcw_rfault : partner_rfault;
	assign rf_live  = next_rf_hold;
	assign jab_live = ev.jab_enable & ev.jab_event;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cap            <= `PSTAT_CAP_RESET;
			pre_sup        <= `PSTAT_PRE_RESET;
			rf_hold        <= 1'b0;
			partner_rfault <= 1'b0;
		end else begin
			cap            <= next_cap;
			pre_sup        <= next_pre_sup;
			rf_hold        <= next_rf_hold;
			partner_rfault <= next_partner_rfault;
		end
	end

	pstat_latch #(.KIND(PSTAT_LATCH_HIGH)) u_an (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.live    (an_live),
		.rd_clr  (rd_status),
		.q       (an_q)
	);

	pstat_latch #(.KIND(PSTAT_LATCH_HIGH)) u_rf (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.live    (rf_live),
		.rd_clr  (rd_shared),
		.q       (rf_q)
	);

	// link_ok arrives already judged by the link monitor
	pstat_latch #(.KIND(PSTAT_LATCH_LOW)) u_link (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.live    (ev.link_ok),
		.rd_clr  (rd_shared),
		.q       (link_q)
	);

	pstat_latch #(.KIND(PSTAT_LATCH_HIGH)) u_jab (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.live    (jab_live),
		.rd_clr  (rd_shared),
		.q       (jab_q)
	);

	// jabber disabled forces the visible bit low
	always_comb begin
		status_word                      = 16'h0000;
		status_word[`PSTAT_BIT_T4]       = 1'b0;
		status_word[`PSTAT_BIT_TX_FD:`PSTAT_BIT_T_HD] = cap;
		status_word[`PSTAT_BIT_PRE_SUP]  = pre_sup;
		status_word[`PSTAT_BIT_AN_DONE]  = an_q & ev.an_enable;
		status_word[`PSTAT_BIT_RFAULT]   = rf_q;
		status_word[`PSTAT_BIT_AN_ABLE]  = 1'b1;
		status_word[`PSTAT_BIT_LINK]     = link_q;
		status_word[`PSTAT_BIT_JABBER]   = jab_q & ev.jab_enable;
		status_word[`PSTAT_BIT_EXT_CAP]  = 1'b1;
	end

	assign next_rdata = rd_status ? status_word : rdata;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 16'h0000;
		end else begin
			rdata <= next_rdata;
		end
	end

	always_comb begin
		detail_bits                     = 16'h0000;
		detail_bits[`PSTAT_DETAIL_JAB]  = jab_q & ev.jab_enable;
		detail_bits[`PSTAT_DETAIL_RF]   = rf_q;
		detail_bits[`PSTAT_DETAIL_LINK] = link_q;
	end

	assign preamble_skip_en = pre_sup;

	property p_t4_zero;
		@(posedge ref_clk) disable iff (!rstn)
		rd_status |=> !rdata[`PSTAT_BIT_T4];
	endproperty
	a_t4_zero: assert property (p_t4_zero) else $error("t4 bit read as one");

	property p_cap_locked;
		@(posedge ref_clk) disable iff (!rstn)
		(wr_status && !ev.override_en) |=> $stable(cap);
	endproperty
	a_cap_locked: assert property (p_cap_locked) else $error("cap changed without override");

	property p_cap_write;
		@(posedge ref_clk) disable iff (!rstn)
		ow_write |=> cap == $past(acc.wdata[14:11]);
	endproperty
	a_cap_write: assert property (p_cap_write) else $error("cap write lost");

	property p_pre_write;
		@(posedge ref_clk) disable iff (!rstn)
		ow_write |=> preamble_skip_en == $past(acc.wdata[6]);
	endproperty
	a_pre_write: assert property (p_pre_write) else $error("preamble bit write lost");

	property p_resv_zero;
		@(posedge ref_clk) disable iff (!rstn)
		rd_status |=> rdata[10:7] == 4'h0 && rdata[3] && rdata[0];
	endproperty
	a_resv_zero: assert property (p_resv_zero) else $error("fixed bits wrong");

	property p_an_off;
		@(posedge ref_clk) disable iff (!rstn)
		(rd_status && !ev.an_enable) |=> !rdata[`PSTAT_BIT_AN_DONE];
	endproperty
	a_an_off: assert property (p_an_off) else $error("an done while disabled");

	property p_rf_copy;
		@(posedge ref_clk) disable iff (!rstn)
		ev.lcw_valid |=> partner_rfault == $past(ev.lcw_rfault);
	endproperty
	a_rf_copy: assert property (p_rf_copy) else $error("partner fault copy stale");

	property p_rf_latch;
		@(posedge ref_clk) disable iff (!rstn)
		(ev.lcw_valid && ev.lcw_rfault) |=> rf_q;
	endproperty
	a_rf_latch: assert property (p_rf_latch) else $error("remote fault not latched");

	property p_link_low;
		@(posedge ref_clk) disable iff (!rstn)
		(!ev.link_ok && !rd_shared) ##1 (!rd_shared)[*2] |-> !link_q;
	endproperty
	a_link_low: assert property (p_link_low) else $error("link drop lost");

	property p_jab_off;
		@(posedge ref_clk) disable iff (!rstn)
		!ev.jab_enable |-> !detail_bits[`PSTAT_DETAIL_JAB];
	endproperty
	a_jab_off: assert property (p_jab_off) else $error("jabber shown while disabled");

	property p_jab_hold;
		@(posedge ref_clk) disable iff (!rstn)
		(jab_live && !rd_shared) |=> jab_q;
	endproperty
	a_jab_hold: assert property (p_jab_hold) else $error("jabber not latched");

	property p_an_hold;
		@(posedge ref_clk) disable iff (!rstn)
		(an_q && !rd_status) |=> an_q;
	endproperty
	a_an_hold: assert property (p_an_hold) else $error("an done dropped before read");

	property p_pre_locked;
		@(posedge ref_clk) disable iff (!rstn)
		(wr_status && !ev.override_en) |=> $stable(pre_sup);
	endproperty
	a_pre_locked: assert property (p_pre_locked) else $error("preamble bit unlocked");

	property p_cap_rd;
		@(posedge ref_clk) disable iff (!rstn)
		rd_status |=> rdata[14:11] == $past(cap);
	endproperty
	a_cap_rd: assert property (p_cap_rd) else $error("cap bits misread");

	property p_pre_rd;
		@(posedge ref_clk) disable iff (!rstn)
		rd_status |=> rdata[6] == $past(pre_sup);
	endproperty
	a_pre_rd: assert property (p_pre_rd) else $error("preamble bit misread");

	property p_an_set;
		@(posedge ref_clk) disable iff (!rstn)
		an_live |=> an_q;
	endproperty
	a_an_set: assert property (p_an_set) else $error("an done not latched");

	property p_an_clear;
		@(posedge ref_clk) disable iff (!rstn)
		(rd_status && !an_live) |=> !an_q;
	endproperty
	a_an_clear: assert property (p_an_clear) else $error("an done kept after read");

	property p_rf_level;
		@(posedge ref_clk) disable iff (!rstn)
		(ev.lcw_valid && !ev.lcw_rfault) |=> !rf_hold;
	endproperty
	a_rf_level: assert property (p_rf_level) else $error("fault level stale");

	property p_rf_clear;
		@(posedge ref_clk) disable iff (!rstn)
		(rd_shared && !rf_live) |=> !rf_q;
	endproperty
	a_rf_clear: assert property (p_rf_clear) else $error("remote fault kept after read");

	property p_link_drop;
		@(posedge ref_clk) disable iff (!rstn)
		!ev.link_ok |=> !link_q;
	endproperty
	a_link_drop: assert property (p_link_drop) else $error("link drop not latched");

	property p_link_back;
		@(posedge ref_clk) disable iff (!rstn)
		(rd_shared && ev.link_ok) |=> link_q;
	endproperty
	a_link_back: assert property (p_link_back) else $error("link not restored by read");

	property p_jab_clear;
		@(posedge ref_clk) disable iff (!rstn)
		(rd_shared && !jab_live) |=> !jab_q;
	endproperty
	a_jab_clear: assert property (p_jab_clear) else $error("jabber kept after read");

	property p_shared;
		@(posedge ref_clk) disable iff (!rstn)
		rd_status |=> rdata[4] == $past(detail_bits[1]) && rdata[2] == $past(detail_bits[0])
			&& rdata[1] == $past(detail_bits[2]);
	endproperty
	a_shared: assert property (p_shared) else $error("shared bits differ");

	c_ow_write:  cover property (@(posedge ref_clk) disable iff (!rstn) ow_write);
	c_rf_clear:  cover property (@(posedge ref_clk) disable iff (!rstn) rf_q && rd_detail);
	c_link_drop: cover property (@(posedge ref_clk) disable iff (!rstn) link_q ##1 !link_q);
	c_jab:       cover property (@(posedge ref_clk) disable iff (!rstn) jab_live);
endmodule // pstat_core
`default_nettype wire

// >>> tb/pstat_sta.sv
/*
 * Management station model: status and detailed status reads, status writes.
 * Assumes pstat_core samples one-cycle strobes on the rising ref_clk edge.
 */
`default_nettype none
module pstat_sta
	import pstat_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic [15:0] rdata,
	output var  pstat_acc_t  acc
);
	timeunit 1ns;
	timeprecision 1ps;

	initial acc = '0;

	// reserved bits ten down to seven always go out at their default zero
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		acc <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d & 16'hF87F};
		@(posedge ref_clk);
		acc <= '0;
	endtask

	// rdata holds after the answer, so one spare edge is safe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		acc <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge ref_clk);
		acc <= '0;
		@(posedge ref_clk);
		d = rdata;
	endtask
endmodule // pstat_sta
`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench of the basic link status register.
 * Assumes pstat_core and the station model pstat_sta; the bench drives the events.
 */
`default_nettype none
`include "pstat_consts.svh"
module tb
	import pstat_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk;
	logic        rstn;
	pstat_ev_t   ev;
	pstat_acc_t  acc;
	logic [15:0] rdata;
	logic [15:0] detail_bits;
	logic        partner_rfault;
	logic        preamble_skip_en;
	logic [15:0] v;
	int          failures;
	int          checked;

	pstat_core u_pstat_core (.ref_clk, .rstn, .acc, .ev, .rdata, .detail_bits,
		.partner_rfault, .preamble_skip_en);
	pstat_sta u_pstat_sta (.ref_clk, .rdata, .acc);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rds(input string n, input logic [15:0] e);
		u_pstat_sta.rd(`PSTAT_REG_ADDR, v);
		cmp(n, e, v);
	endtask

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic t_reset();
		rds("status after reset", 16'h7809);
		rds("status reread", 16'h780D);
		cmp("preamble skip", 16'h0000, {15'h0000, preamble_skip_en});
		$display("test reset done");
	endtask

	task automatic t_override();
		u_pstat_sta.wr(`PSTAT_REG_ADDR, 16'h0040);
		rds("write locked", 16'h780D);
		ev.override_en <= 1'b1;
		u_pstat_sta.wr(`PSTAT_REG_ADDR, 16'h8040);
		rds("write unlocked", 16'h004D);
		cmp("preamble skip", 16'h0001, {15'h0000, preamble_skip_en});
		u_pstat_sta.wr(`PSTAT_REG_ADDR, 16'h7800);
		rds("caps restored", 16'h780D);
		ev.override_en <= 1'b0;
		$display("test override done");
	endtask

	task automatic t_an();
		ev.an_enable <= 1'b1;
		rds("negotiating", 16'h780D);
		ev.an_done <= 1'b1;
		@(posedge ref_clk);
		ev.an_done <= 1'b0;
		rds("done latched", 16'h782D);
		rds("done reread", 16'h780D);
		ev.an_enable <= 1'b0;
		ev.an_done <= 1'b1;
		rds("done disabled", 16'h780D);
		ev.an_done <= 1'b0;
		$display("test negotiation done");
	endtask

	task automatic t_rf();
		ev.lcw_valid <= 1'b1;
		ev.lcw_rfault <= 1'b1;
		@(posedge ref_clk);
		ev.lcw_valid <= 1'b0;
		ev.lcw_rfault <= 1'b0;
		tick();
		cmp("partner fault", 16'h0001, {15'h0000, partner_rfault});
		cmp("detail fault", 16'h0002, detail_bits & 16'h0002);
		@(posedge ref_clk);
		ev.lcw_valid <= 1'b1;
		@(posedge ref_clk);
		ev.lcw_valid <= 1'b0;
		tick();
		cmp("partner cleared", 16'h0000, {15'h0000, partner_rfault});
		rds("fault latched", 16'h781D);
		ev.lcw_valid <= 1'b1;
		ev.lcw_rfault <= 1'b1;
		@(posedge ref_clk);
		// a clean code word drops the live level so the read can clear the latch
		ev.lcw_rfault <= 1'b0;
		@(posedge ref_clk);
		ev.lcw_valid <= 1'b0;
		u_pstat_sta.rd(`PSTAT_DETAIL_ADDR, v);
		rds("fault cleared by detail", 16'h780D);
		$display("test remote fault done");
	endtask

	task automatic t_link();
		ev.link_ok <= 1'b0;
		@(posedge ref_clk);
		ev.link_ok <= 1'b1;
		tick();
		cmp("detail link", 16'h0000, detail_bits & 16'h0001);
		rds("link drop kept", 16'h7809);
		rds("link back", 16'h780D);
		$display("test link done");
	endtask

	task automatic t_jab();
		ev.jab_enable <= 1'b1;
		ev.jab_event <= 1'b1;
		@(posedge ref_clk);
		ev.jab_event <= 1'b0;
		tick();
		cmp("detail jabber", 16'h0004, detail_bits & 16'h0004);
		rds("jabber latched", 16'h780F);
		ev.jab_event <= 1'b1;
		@(posedge ref_clk);
		ev.jab_event <= 1'b0;
		u_pstat_sta.rd(`PSTAT_DETAIL_ADDR, v);
		rds("jabber cleared by detail", 16'h780D);
		ev.jab_enable <= 1'b0;
		ev.jab_event <= 1'b1;
		rds("jabber disabled", 16'h780D);
		ev.jab_event <= 1'b0;
		$display("test jabber done");
	endtask

	task automatic t_rerst();
		ev.override_en <= 1'b1;
		u_pstat_sta.wr(`PSTAT_REG_ADDR, 16'h0040);
		rds("before second reset", 16'h004D);
		ev.override_en <= 1'b0;
		rstn <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		cmp("preamble after reset", 16'h0000, {15'h0000, preamble_skip_en});
		rds("status after second reset", 16'h7809);
		rds("reread after second reset", 16'h780D);
		$display("test second reset done");
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		conclude();
	end

	initial begin
		failures = 0;
		checked = 0;
		rstn = 1'b0;
		ev = '0;
		ev.link_ok = 1'b1;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset();
		t_override();
		t_an();
		t_rf();
		t_link();
		t_jab();
		t_rerst();
		conclude();
	end
endmodule // tb
`default_nettype wire
